// file: logic/host_irq_pin_params.svh
// Purpose: offsets, field positions, reset values and timing counts of the host interrupt block
// Assumes: 10 MHz core clock
// Notes: definitions only
`ifndef HOST_IRQ_PIN_PARAMS_SVH
`define HOST_IRQ_PIN_PARAMS_SVH

// ====================================
// register offsets
`define HL_CTRL_OFS 8'h06
`define IRQ_CFG_OFS 8'h07

// ====================================
// host_link_control fields
`define HL_ABORT_LSB 0
`define HL_SUSP_BIT 4
`define HL_TS_SEL_BIT 6
`define HL_ASYNC_BIT 7
`define HL_WR_MASK 8'hDF
`define HL_CTRL_RST 8'h00

// ====================================
// interrupt_output_config fields
`define CFG_MASK_WAKE_BIT 0
`define CFG_MASK_NWAKE_BIT 1
`define CFG_MASK_STAT_BIT 2
`define CFG_MASK_DBG_BIT 3
`define CFG_MASK_FAULT_BIT 4
`define CFG_LOW_BIT 5
`define CFG_PULSE_BIT 6
`define CFG_OD_BIT 7
`define IRQ_CFG_RST 8'h00

// ====================================
// timing and sizes
`define CLK_PERIOD_NS 100
`define PULSE_TIME_NS 10000
`define PULSE_CYCLES (`PULSE_TIME_NS / `CLK_PERIOD_NS)
`define DISCARD_BYTES 32

`endif

// file: logic/host_irq_pin_pkg.sv
// Purpose: types shared by the host interrupt block
// Assumes: constants come from host_irq_pin_params.svh
// Notes: none
package host_irq_pin_pkg;

	// ====================================
	// register contents
	typedef struct packed {
		logic async_status;
		logic ts_sel;
		logic rsvd;
		logic suspended;
		logic [3:0] abort;
	} link_ctrl_t;

	typedef struct packed {
		logic open_drain;
		logic pulse;
		logic active_low;
		logic mask_fault;
		logic mask_debug;
		logic mask_status;
		logic mask_nwake;
		logic mask_wake;
	} irq_cfg_t;

	// ====================================
	// module state
	typedef struct packed {
		link_ctrl_t link;
		irq_cfg_t cfg;
		logic warm_boot;
		logic irq_prev;
		logic [3:0] abort_prev;
		logic [3:0] discard;
		logic ts_event;
		logic [39:0] ts_hold;
		logic [7:0] rdata;
	} ctrl_state_t;

	typedef enum logic [1:0] {
		PIN_IDLE,
		PIN_PULSE,
		PIN_WAIT
	} pin_mode_t;

	typedef struct packed {
		pin_mode_t mode;
		logic [6:0] count;
		logic active;
	} pin_state_t;

endpackage : host_irq_pin_pkg

// file: logic/irq_pin_driver.sv
// Purpose: shapes the raw interrupt level into the configured pin waveform
// Assumes: config fields stable enough between events
// Notes: pulse restarts only after the request drops
`timescale 1ns/100ps
`include "host_irq_pin_params.svh"

module irq_pin_driver
	import host_irq_pin_pkg::*;
#(
	parameter logic [6:0] PULSE_LEN = 7'(`PULSE_CYCLES)
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_i,
	input wire irq_cfg_t cfg_i,
	output logic pin_o,
	output logic pin_oe_o
);

	pin_state_t s_q;
	pin_state_t s_d;

	// ====================================
	// level or pulse shaping
	always_comb begin
		s_d = s_q;
		unique case (s_q.mode)
			PIN_IDLE: begin
				if (req_i && cfg_i.pulse) begin // RULE20
					s_d.mode = PIN_PULSE;
					s_d.count = PULSE_LEN - 7'h01;
				end
			end
			PIN_PULSE: begin
				if (s_q.count == 7'h00) begin
					s_d.mode = PIN_WAIT;
				end else begin
					s_d.count = s_q.count - 7'h01;
				end
			end
			PIN_WAIT: begin
				// one pulse per request; rearm once it is withdrawn
				if (!req_i) begin
					s_d.mode = PIN_IDLE;
				end
			end
		endcase
		s_d.active = cfg_i.pulse ? (s_d.mode == PIN_PULSE) : req_i; // RULE12
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '{mode: PIN_IDLE, count: 7'h00, active: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// ====================================
	// polarity and drive type
	always_comb begin
		if (cfg_i.open_drain) begin
			// open drain can only pull low; the released level comes from the board
			pin_o = 1'b0; // RULE20
			pin_oe_o = s_q.active ^ ~cfg_i.active_low;
		end else begin
			pin_o = s_q.active ^ cfg_i.active_low; // RULE19
			pin_oe_o = 1'b1;
		end
	end

endmodule : irq_pin_driver

// file: logic/host_irq_ctrl.sv
// Purpose: host link control and host interrupt configuration registers with interrupt output
// Assumes: register port driven by the host serial interface on the core clock
// Notes: warm reset models watchdog or fatal-error reset of the core
//
// Behaviour
// RULE1: timestamp select resets 0, picks capture source
// RULE2: select set suppresses timestamp status packet
// RULE3: bit 7 selects async status fifo
// RULE4: interrupt holds until pending fifos drained/aborted
// RULE5: abort bits never self-clear
// RULE6: host rewrites aborts, holds them 2 ms
// RULE7: abort discards 32 bytes in short cases
// RULE8: interrupt held off until firmware ready; after a warm reset warm_boot enables it without FW_INIT_DONE_I
// RULE9: config survives watchdog or fatal reset
// RULE10: interrupt set up after firmware load
// RULE11: host polls boot status after boot
// RULE12: latest written config shapes later interrupts
// RULE13: config resets to zero default mode
// RULE14: interrupt asserted after firmware init completes
// RULE15: five mask bits block their sources
// RULE16: masking keeps pending condition recorded
// RULE17: abort clears channel buffer and pending
// RULE18: suspended host sees only wake-up events
// RULE19: bit 5 selects active low polarity
// RULE20: bit 6 pulse form, bit 7 open drain
`timescale 1ns/100ps
`include "host_irq_pin_params.svh"

module host_irq_ctrl
	import host_irq_pin_pkg::*;
#(
	parameter int TS_WIDTH = 40
) (
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	input wire logic WARM_RST_I,
	input wire logic FW_INIT_DONE_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	output logic [7:0] REG_RDATA_O,
	input wire logic [3:0] CH_PENDING_I,
	input wire logic DEBUG_PENDING_I,
	input wire logic FAULT_PENDING_I,
	input wire logic [3:0] CH_SHORT_XFER_I,
	input wire logic TS_REQ_WR_I,
	input wire logic [TS_WIDTH-1:0] TIME_I,
	output logic [3:0] CH_ABORT_O,
	output logic [3:0] CH_DISCARD_O,
	output logic [3:0] CH_PENDING_O,
	output logic ASYNC_STATUS_O,
	output logic HOST_SUSPENDED_O,
	output logic TS_STATUS_EVENT_O,
	output logic [TS_WIDTH-1:0] IRQ_TIMESTAMP_O,
	output logic IRQ_ASSERTED_O,
	output logic HOST_IRQ_PIN_O,
	output logic HOST_IRQ_PIN_OE_O
);

	ctrl_state_t s_q;
	ctrl_state_t s_d;
	logic [3:0] ch_live;
	logic wake_src;
	logic other_src;
	logic irq_enable;
	logic irq_raw;

	// ====================================
	// helpers
	function automatic logic [7:0] pick_reg(input logic [7:0] addr, input link_ctrl_t link,
		input irq_cfg_t cfg);
		logic [7:0] r;
		r = 8'h00;
		if (addr == `HL_CTRL_OFS) begin
			r = link & `HL_WR_MASK;
		end else if (addr == `IRQ_CFG_OFS) begin
			r = cfg;
		end
		return r;
	endfunction : pick_reg

	// ====================================
	// interrupt sources
	always_comb begin
		// an aborted channel drops out; its fifo data stays upstream
		ch_live = CH_PENDING_I & ~s_q.link.abort; // RULE17
		// masks only gate the interrupt request, CH_PENDING_O still shows the condition
		wake_src = ch_live[1] & ~s_q.cfg.mask_wake; // RULE15 RULE16
		other_src = ch_live[0]
			| (ch_live[2] & ~s_q.cfg.mask_nwake)
			| (ch_live[3] & ~s_q.cfg.mask_status)
			| (DEBUG_PENDING_I & ~s_q.cfg.mask_debug)
			| (FAULT_PENDING_I & ~s_q.cfg.mask_fault); // RULE15
		// firmware must be up, or the config was kept over a warm reset
		irq_enable = FW_INIT_DONE_I | s_q.warm_boot; // RULE8 RULE10 RULE14
		// level follows pending sources, so it holds until drained or aborted
		irq_raw = irq_enable & (wake_src | (other_src & ~s_q.link.suspended)); // RULE4 RULE18
	end

	// ====================================
	// register and event state
	always_comb begin
		s_d = s_q;
		s_d.ts_event = 1'b0;
		s_d.irq_prev = irq_raw;
		s_d.abort_prev = s_q.link.abort;
		s_d.rdata = REG_RD_I ? pick_reg(REG_ADDR_I, s_q.link, s_q.cfg) : 8'h00;
		if (REG_WR_I && REG_ADDR_I == `HL_CTRL_OFS) begin
			// aborts change only on host writes or a warm reset
			s_d.link = REG_WDATA_I & `HL_WR_MASK; // RULE5 RULE6 RULE3
		end
		if (REG_WR_I && REG_ADDR_I == `IRQ_CFG_OFS) begin
			s_d.cfg = REG_WDATA_I; // RULE12
		end
		// discard only when the abort would lose the 32-byte block anyway
		s_d.discard = s_q.link.abort & ~s_q.abort_prev & CH_SHORT_XFER_I; // RULE7
		if (s_q.link.ts_sel) begin
			if (TS_REQ_WR_I) begin
				s_d.ts_hold = TIME_I; // RULE1
			end
		end else begin
			if (irq_raw && !s_q.irq_prev) begin
				s_d.ts_hold = TIME_I; // RULE1
			end
			s_d.ts_event = TS_REQ_WR_I; // RULE2
		end
		if (WARM_RST_I) begin
			// interrupt config deliberately survives a warm reset
			s_d.link = `HL_CTRL_RST;
			s_d.warm_boot = 1'b1; // RULE9
			s_d.ts_hold = '0;
			s_d.discard = 4'h0;
			s_d.ts_event = 1'b0;
			s_d.irq_prev = 1'b0;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			s_q <= '0;
			s_q.link <= `HL_CTRL_RST; // RULE1
			s_q.cfg <= `IRQ_CFG_RST; // RULE13
		end else begin
			s_q <= s_d;
		end
	end

	// ====================================
	// pin shaping
	irq_pin_driver u_pin (
		.clk_i(CLOCK_I),
		.rst_n_i(RST_N_I),
		.req_i(s_q.irq_prev),
		.cfg_i(s_q.cfg),
		.pin_o(HOST_IRQ_PIN_O),
		.pin_oe_o(HOST_IRQ_PIN_OE_O)
	);

	// ====================================
	// outputs
	assign REG_RDATA_O = s_q.rdata;
	assign CH_ABORT_O = s_q.link.abort; // RULE17
	assign CH_DISCARD_O = s_q.discard;
	assign CH_PENDING_O = ch_live;
	assign ASYNC_STATUS_O = s_q.link.async_status; // RULE3
	assign HOST_SUSPENDED_O = s_q.link.suspended;
	assign TS_STATUS_EVENT_O = s_q.ts_event;
	assign IRQ_TIMESTAMP_O = s_q.ts_hold[TS_WIDTH-1:0];
	assign IRQ_ASSERTED_O = s_q.irq_prev; // RULE4

endmodule : host_irq_ctrl

// file: testbench/host_irq_ctrl_assertions.sv
// Purpose: port checks of host_irq_ctrl
// Assumes: one clock, async low reset
// Notes: warm reset tracked locally
`timescale 1ns/100ps
module host_irq_ctrl_chk (
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	input wire logic WARM_RST_I,
	input wire logic FW_INIT_DONE_I,
	input wire logic REG_WR_I,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic [3:0] CH_PENDING_I,
	input wire logic [3:0] CH_SHORT_XFER_I,
	input wire logic TS_REQ_WR_I,
	input wire logic [3:0] CH_ABORT_O,
	input wire logic [3:0] CH_DISCARD_O,
	input wire logic [3:0] CH_PENDING_O,
	input wire logic ASYNC_STATUS_O,
	input wire logic HOST_SUSPENDED_O,
	input wire logic TS_STATUS_EVENT_O,
	input wire logic IRQ_ASSERTED_O
);
	// ====================================
	// helpers
	logic warm_q;
	wire logic lw = REG_WR_I && REG_ADDR_I == 8'h06;
	always_ff @(posedge CLOCK_I or negedge RST_N_I)
		if (!RST_N_I) warm_q <= 1'b0;
		else if (WARM_RST_I) warm_q <= 1'b1;
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RST_N_I);
	// ====================================
	// properties
	property p_ab; !lw && !WARM_RST_I |=> $stable(CH_ABORT_O); endproperty
	a_ab: assert property (p_ab) else $error("abort changed");
	property p_pd; CH_PENDING_O == (CH_PENDING_I & ~CH_ABORT_O); endproperty
	a_pd: assert property (p_pd) else $error("pending kept");
	property p_ts; TS_STATUS_EVENT_O |-> $past(TS_REQ_WR_I); endproperty
	a_ts: assert property (p_ts) else $error("stray ts event");
	property p_wr; lw && !WARM_RST_I |=> ASYNC_STATUS_O == $past(REG_WDATA_I[7])
		&& CH_ABORT_O == $past(REG_WDATA_I[3:0]); endproperty
	a_wr: assert property (p_wr) else $error("link write lost");
	property p_su; HOST_SUSPENDED_O && !CH_PENDING_I[1] |=> !IRQ_ASSERTED_O; endproperty
	a_su: assert property (p_su) else $error("irq while suspended");
	property p_fw; !FW_INIT_DONE_I && !warm_q && !WARM_RST_I |=> !IRQ_ASSERTED_O; endproperty
	a_fw: assert property (p_fw) else $error("irq before init");
	property p_on; FW_INIT_DONE_I && !HOST_SUSPENDED_O && CH_PENDING_O[0] && !WARM_RST_I
		|=> IRQ_ASSERTED_O; endproperty
	a_on: assert property (p_on) else $error("irq missing");
	property p_dc; $rose(CH_ABORT_O[0]) && CH_SHORT_XFER_I[0] && !WARM_RST_I
		|=> CH_DISCARD_O[0]; endproperty
	a_dc: assert property (p_dc) else $error("no discard");
	c_dc: cover property (CH_DISCARD_O[0]);
	c_on: cover property ($rose(IRQ_ASSERTED_O));
	c_ts: cover property (TS_STATUS_EVENT_O);
endmodule : host_irq_ctrl_chk
bind host_irq_ctrl host_irq_ctrl_chk chk_u (.*);

// file: testbench/host_model.sv
// Purpose: host processor on the register strobes
// Assumes: one-cycle strobes
// Notes: released lines show inverted values
`timescale 1ns/100ps
module host_model (
	input wire logic clk_i,
	output logic wr_o = 1'b0,
	output logic rd_o = 1'b0,
	output logic [7:0] addr_o = 8'hFF,
	output logic [7:0] wdata_o = 8'hFF,
	input wire logic [7:0] rdata_i
);
	// whole byte each time, so all four abort bits are restated
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(negedge clk_i);
		d = rdata_i;
	endtask : rd
endmodule : host_model

// file: testbench/host_irq_ctrl_tb_top.sv
// Purpose: self-checking bench of host_irq_ctrl
// Assumes: host_model drives the register strobes
// Notes: pin line has a pull-up
`timescale 1ns/100ps
module host_irq_ctrl_tb_top;
	logic CLOCK_I = 1'b0, RST_N_I = 1'b0, WARM_RST_I = 1'b0, FW_INIT_DONE_I = 1'b0;
	logic REG_WR_I, REG_RD_I, TS_REQ_WR_I = 1'b0, DEBUG_PENDING_I = 1'b0, FAULT_PENDING_I = 1'b0;
	logic ASYNC_STATUS_O, HOST_SUSPENDED_O, TS_STATUS_EVENT_O, IRQ_ASSERTED_O;
	logic HOST_IRQ_PIN_O, HOST_IRQ_PIN_OE_O;
	logic [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O, cf [4] = '{8'h00, 8'h20, 8'h80, 8'hA0};
	logic [3:0] CH_PENDING_I = 4'h0, CH_SHORT_XFER_I = 4'hF, CH_ABORT_O, CH_DISCARD_O, CH_PENDING_O;
	logic [39:0] TIME_I = 40'h0, IRQ_TIMESTAMP_O, ts_x;
	wire logic pin_w = HOST_IRQ_PIN_OE_O ? HOST_IRQ_PIN_O : 1'b1;
	int err_count = 0;
	int n_checks = 0;
	always #50 CLOCK_I = ~CLOCK_I;
	always @(posedge CLOCK_I) TIME_I <= TIME_I + 40'h1;
	host_irq_ctrl dut_u (.*);
	host_model host_u (.clk_i(CLOCK_I), .wr_o(REG_WR_I), .rd_o(REG_RD_I), .addr_o(REG_ADDR_I),
		.wdata_o(REG_WDATA_I), .rdata_i(REG_RDATA_O));
	// ====================================
	// tasks
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR t=%0t got %0h exp %0h", $time, g, e);
		end
	endtask : chk
	task automatic cy(input int n);
		repeat (n) @(negedge CLOCK_I);
	endtask : cy
	task automatic pend(input logic [3:0] v);
		@(posedge CLOCK_I) CH_PENDING_I <= v;
		cy(3);
	endtask : pend
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host_u.rd(a, d);
		chk(d, e);
	endtask : rc
	task automatic tsreq(input logic ev);
		@(posedge CLOCK_I) TS_REQ_WR_I <= 1'b1;
		@(posedge CLOCK_I) TS_REQ_WR_I <= 1'b0;
		ts_x = TIME_I;
		cy(1);
		chk(TS_STATUS_EVENT_O, ev);
	endtask : tsreq
	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize
	// ====================================
	// tests
	initial begin
		cy(4);
		@(posedge CLOCK_I) RST_N_I <= 1'b1;
		rc(8'h06, 8'h00);
		rc(8'h07, 8'h00);
		rc(8'h08, 8'h00);
		$display("reset test done");
		pend(4'h1);
		chk(IRQ_ASSERTED_O, 1'b0);
		@(posedge CLOCK_I) FW_INIT_DONE_I <= 1'b1;
		cy(3);
		chk(pin_w, 1'b1);
		host_u.wr(8'h06, 8'h01);
		// discard pulse stands one cycle, one edge after the write is taken
		cy(2);
		chk(CH_DISCARD_O, 4'h1);
		// host keeps the abort for its full hold time
		cy(20000);
		chk({CH_ABORT_O, CH_PENDING_O, IRQ_ASSERTED_O}, 9'h020);
		host_u.wr(8'h06, 8'h00);
		pend(4'h0);
		$display("abort test done");
		for (int i = 0; i < 3; i++) begin
			host_u.wr(8'h07, 8'h01 << i);
			pend(4'h2 << i);
			chk(IRQ_ASSERTED_O, 1'b0);
			host_u.wr(8'h07, 8'h00);
			cy(3);
			chk(IRQ_ASSERTED_O, 1'b1);
			pend(4'h0);
		end
		foreach (cf[i]) begin
			host_u.wr(8'h07, cf[i]);
			cy(3);
			chk({pin_w, HOST_IRQ_PIN_OE_O}, {cf[i][5], ~cf[i][7] | ~cf[i][5]});
			pend(4'h2);
			chk({pin_w, HOST_IRQ_PIN_OE_O}, {~cf[i][5], ~cf[i][7] | cf[i][5]});
			pend(4'h0);
		end
		host_u.wr(8'h07, 8'h40);
		pend(4'h2);
		chk(pin_w, 1'b1);
		cy(105);
		chk({pin_w, IRQ_ASSERTED_O}, 2'b01);
		pend(4'h0);
		host_u.wr(8'h07, 8'h00);
		$display("config test done");
		host_u.wr(8'h06, 8'h10);
		pend(4'h4);
		chk(IRQ_ASSERTED_O, 1'b0);
		pend(4'h2);
		chk({HOST_SUSPENDED_O, IRQ_ASSERTED_O}, 2'b11);
		pend(4'h0);
		tsreq(1'b1);
		host_u.wr(8'h06, 8'hC0);
		tsreq(1'b0);
		chk({ASYNC_STATUS_O, IRQ_TIMESTAMP_O}, {1'b1, ts_x});
		$display("link test done");
		host_u.wr(8'h07, 8'h20);
		@(posedge CLOCK_I) begin
			FW_INIT_DONE_I <= 1'b0;
			WARM_RST_I <= 1'b1;
		end
		@(posedge CLOCK_I) WARM_RST_I <= 1'b0;
		rc(8'h07, 8'h20);
		rc(8'h06, 8'h00);
		pend(4'h1);
		chk({IRQ_ASSERTED_O, pin_w}, 2'b10);
		$display("boot test done");
		summarize();
	end
	initial begin
		#3000000;
		err_count++;
		summarize();
	end
endmodule : host_irq_ctrl_tb_top
